// ==== rtl/hbs_pkg.sv ====
// Purpose: Shared constants and types for the holding brake sequencer
// Assumes: 200 MHz system clock, AXI4-Lite register access
// Notes on behaviour
// - Servo off or alarm applies the brake
// - Brake output only on pairs coded four
// - Stopped servo-off: brake now, power after wait
// - Positive on-wait: release brake, then power
// - Negative on-wait: power first, then release
// - Alarm cuts motor power at once
// - Running stop: brake when speed below threshold
// - Running stop: brake when wait time expires
// - Speed threshold resets to 100, live
// - Brake wait resets 50; servo waits 0
`default_nettype none

package hbs_pkg;
    // Clock and millisecond tick
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned MS_IN_PS = 1_000_000_000;
    localparam int unsigned CYCLES_PER_MS = MS_IN_PS / CLK_PERIOD_PS;
    // Field widths
    localparam int unsigned SON_W = 12;
    localparam int unsigned SOFF_W = 9;
    localparam int unsigned THR_W = 7;
    localparam int unsigned BWAIT_W = 7;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned N_PAIRS = 2;
    localparam int unsigned SPD_W = 16;
    localparam int unsigned MS_W = 13;
    localparam int unsigned ADDR_W = 8;
    localparam logic [MS_W-1:0] STEP_10MS = 13'h000A;
    // Reset values
    localparam logic [SON_W-1:0] SON_RST = 12'h000;
    localparam logic [SOFF_W-1:0] SOFF_RST = 9'h000;
    localparam logic [THR_W-1:0] THR_RST = 7'h64;
    localparam logic [BWAIT_W-1:0] BWAIT_RST = 7'h32;
    localparam logic [SEL_W-1:0] SEL_NONE = 4'hF;
    localparam logic [SEL_W-1:0] SEL_BRAKE = 4'h4;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_SON = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SOFF = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_THR = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_BWAIT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_SEL = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14;
    // Status fields
    localparam int unsigned STAT_BRK_BIT = 0;
    localparam int unsigned STAT_PWR_BIT = 1;
    localparam int unsigned STAT_ST_LSB = 4;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_REL_WAIT,
        ST_PWR_WAIT,
        ST_RUN,
        ST_OFF_WAIT,
        ST_RUNDOWN
    } hbs_state_e;
endpackage

`default_nettype wire

// ==== rtl/hbs_tick_gen.sv ====
// Purpose: One-cycle enable pulse every millisecond
// Assumes: Single system clock
// Notes: Period is a parameter so benches can shorten it
`timescale 1ns/1ps
`default_nettype none

module hbs_tick_gen #(
    parameter int unsigned CYCLES = hbs_pkg::CYCLES_PER_MS
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic tick
);
    logic [31:0] div_ff;

    // Free-running divider
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            div_ff <= 32'h0000_0000;
        else if (div_ff == CYCLES - 1)
            div_ff <= 32'h0000_0000;
        else
            div_ff <= div_ff + 32'h0000_0001;
    end

    assign tick = (div_ff == CYCLES - 1);
endmodule // hbs_tick_gen

`default_nettype wire

// ==== rtl/hbs_ms_timer.sv ====
// Purpose: Millisecond elapsed counter for brake and power delays
// Assumes: tick is a one-cycle enable
// Notes: Saturates so a long wait never wraps to a short one
`timescale 1ns/1ps
`default_nettype none

module hbs_ms_timer #(
    parameter int unsigned W = hbs_pkg::MS_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic clr,
    output logic [W-1:0] cnt_ms
);
    logic [W-1:0] cnt_ff;

    // Clear wins over a coincident tick
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= '0;
        else if (clr)
            cnt_ff <= '0;
        else if (tick && !(&cnt_ff))
            cnt_ff <= cnt_ff + W'(1);
    end

    assign cnt_ms = cnt_ff;
endmodule // hbs_ms_timer

`default_nettype wire

// ==== rtl/hbs_top.sv ====
// Purpose: Holding brake sequencer with AXI4-Lite settings
// Assumes: Commands, alarm and speed synchronous to sys_clk
// Notes: Motor counts as turning at or above the speed threshold
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module hbs_top #(
    parameter int unsigned CYCLES_PER_MS = hbs_pkg::CYCLES_PER_MS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic servo_on_cmd,
    input wire logic alarm,
    input wire logic [hbs_pkg::SPD_W-1:0] motor_speed,
    output logic brake_release_out,
    output logic motor_power_en,
    output logic [hbs_pkg::N_PAIRS-1:0] out_pair,
    input wire logic [hbs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hbs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int unsigned MW = hbs_pkg::MS_W;

    // Byte-lane merge of a write into a register image
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        end
        return res;
    endfunction

    // Setting in 10 ms steps to milliseconds
    function automatic logic [MW-1:0] ms_of_10(input logic [MW-1:0] v);
        return MW'(v * hbs_pkg::STEP_10MS);
    endfunction

    // Settings
    logic signed [hbs_pkg::SON_W-1:0] son_wait_ff;
    logic [hbs_pkg::SOFF_W-1:0] soff_wait_ff;
    logic [hbs_pkg::THR_W-1:0] thr_ff;
    logic [hbs_pkg::BWAIT_W-1:0] bwait_ff;
    logic [hbs_pkg::SEL_W*hbs_pkg::N_PAIRS-1:0] sel_ff;
    // Bus state
    logic aw_got_ff;
    logic w_got_ff;
    logic [hbs_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic wr_fire;
    logic wr_seen_ff;
    // Sequencer state
    hbs_pkg::hbs_state_e state_ff;
    hbs_pkg::hbs_state_e nxt_state;
    logic son_prev_ff;
    logic son_rise;
    logic turning;
    logic brk_ff;
    logic pwr_ff;
    logic nxt_brk;
    logic nxt_pwr;
    logic tick;
    logic [MW-1:0] cnt_ms;
    logic [MW-1:0] son_ms;
    logic [MW-1:0] soff_ms;
    logic [MW-1:0] bwait_ms;
    logic [hbs_pkg::N_PAIRS-1:0] pair_ff;

    hbs_tick_gen #(
        .CYCLES(CYCLES_PER_MS)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick)
    );

    // Counter restarts on every state change
    hbs_ms_timer #(
        .W(MW)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .clr(nxt_state != state_ff),
        .cnt_ms(cnt_ms)
    );

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_got_ff <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_got_ff <= 1'b0;
        end
    end

    // Setting registers; new values act at once
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            son_wait_ff <= hbs_pkg::SON_RST;
            soff_wait_ff <= hbs_pkg::SOFF_RST;
            thr_ff <= hbs_pkg::THR_RST;
            bwait_ff <= hbs_pkg::BWAIT_RST;
            sel_ff <= {hbs_pkg::N_PAIRS{hbs_pkg::SEL_NONE}};
            wr_seen_ff <= 1'b0;
        end
        else if (wr_fire)
        begin
            wr_seen_ff <= 1'b1;
            unique case (awaddr_ff)
                hbs_pkg::OFS_SON:
                    son_wait_ff <= hbs_pkg::SON_W'(merge_strb(32'(son_wait_ff), wdata_ff, wstrb_ff));
                hbs_pkg::OFS_SOFF:
                    soff_wait_ff <= hbs_pkg::SOFF_W'(merge_strb(32'(soff_wait_ff), wdata_ff, wstrb_ff));
                hbs_pkg::OFS_THR:
                    thr_ff <= hbs_pkg::THR_W'(merge_strb(32'(thr_ff), wdata_ff, wstrb_ff));
                hbs_pkg::OFS_BWAIT:
                    bwait_ff <= hbs_pkg::BWAIT_W'(merge_strb(32'(bwait_ff), wdata_ff, wstrb_ff));
                hbs_pkg::OFS_SEL:
                    sel_ff <= (hbs_pkg::SEL_W*hbs_pkg::N_PAIRS)'(merge_strb(32'(sel_ff), wdata_ff, wstrb_ff));
                default:
                    wr_seen_ff <= 1'b1;
            endcase
        end
    end

    // Write response; unmapped or read-only offsets answer SLVERR
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= hbs_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (awaddr_ff == hbs_pkg::OFS_SON || awaddr_ff == hbs_pkg::OFS_SOFF ||
                         awaddr_ff == hbs_pkg::OFS_THR || awaddr_ff == hbs_pkg::OFS_BWAIT ||
                         awaddr_ff == hbs_pkg::OFS_SEL) ? hbs_pkg::RESP_OKAY : hbs_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // Read channel: one cycle to data, zero above field width except the sign-extended on-wait
    assign s_axi_arready = !rvalid_ff;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= hbs_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_ff)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff <= hbs_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                hbs_pkg::OFS_SON:
                    rdata_ff <= 32'(signed'(son_wait_ff));
                hbs_pkg::OFS_SOFF:
                    rdata_ff <= 32'(soff_wait_ff);
                hbs_pkg::OFS_THR:
                    rdata_ff <= 32'(thr_ff);
                hbs_pkg::OFS_BWAIT:
                    rdata_ff <= 32'(bwait_ff);
                hbs_pkg::OFS_SEL:
                    rdata_ff <= 32'(sel_ff);
                hbs_pkg::OFS_STAT:
                    rdata_ff <= (32'(brk_ff) << hbs_pkg::STAT_BRK_BIT) |
                                (32'(pwr_ff) << hbs_pkg::STAT_PWR_BIT) |
                                (32'(state_ff) << hbs_pkg::STAT_ST_LSB);
                default:
                begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= hbs_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Delay targets in milliseconds
    assign son_ms = (son_wait_ff < 0) ? MW'(-son_wait_ff) : MW'(son_wait_ff);
    assign soff_ms = ms_of_10(MW'(soff_wait_ff));
    assign bwait_ms = ms_of_10(MW'(bwait_ff));
    assign turning = (motor_speed >= hbs_pkg::SPD_W'(thr_ff));
    assign son_rise = servo_on_cmd && !son_prev_ff;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            son_prev_ff <= 1'b0;
        else
            son_prev_ff <= servo_on_cmd;
    end

    // Sequencer; alarm outranks commands; strict compare since tick phase is free, so a wait never ends early
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            hbs_pkg::ST_OFF:
            begin
                if (son_rise && !alarm)
                begin
                    if (son_wait_ff > 0)
                        nxt_state = hbs_pkg::ST_REL_WAIT;
                    else if (son_wait_ff < 0)
                        nxt_state = hbs_pkg::ST_PWR_WAIT;
                    else
                        nxt_state = hbs_pkg::ST_RUN;
                end
            end
            hbs_pkg::ST_REL_WAIT, hbs_pkg::ST_PWR_WAIT, hbs_pkg::ST_RUN:
            begin
                if (alarm || !servo_on_cmd)
                begin
                    if (turning)
                        nxt_state = hbs_pkg::ST_RUNDOWN;
                    else if (alarm || soff_ms == '0 || state_ff == hbs_pkg::ST_REL_WAIT)
                        nxt_state = hbs_pkg::ST_OFF;
                    else
                        nxt_state = hbs_pkg::ST_OFF_WAIT;
                end
                else if (state_ff != hbs_pkg::ST_RUN && cnt_ms > son_ms)
                    nxt_state = hbs_pkg::ST_RUN;
            end
            hbs_pkg::ST_OFF_WAIT:
            begin
                if (alarm || cnt_ms > soff_ms)
                    nxt_state = hbs_pkg::ST_OFF;
            end
            hbs_pkg::ST_RUNDOWN:
            begin
                if (!turning || cnt_ms > bwait_ms)
                    nxt_state = hbs_pkg::ST_OFF;
            end
            default:
                nxt_state = hbs_pkg::ST_OFF;
        endcase
    end

    // Output levels follow the next state
    always_comb
    begin
        nxt_brk = 1'b0;
        nxt_pwr = 1'b0;
        unique case (nxt_state)
            hbs_pkg::ST_REL_WAIT, hbs_pkg::ST_RUNDOWN:
                nxt_brk = 1'b1;
            hbs_pkg::ST_PWR_WAIT, hbs_pkg::ST_OFF_WAIT:
                nxt_pwr = 1'b1;
            hbs_pkg::ST_RUN:
            begin
                nxt_brk = 1'b1;
                nxt_pwr = 1'b1;
            end
            default:
                nxt_brk = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= hbs_pkg::ST_OFF;
            brk_ff <= 1'b0;
            pwr_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            brk_ff <= nxt_brk;
            pwr_ff <= nxt_pwr;
        end
    end

    assign brake_release_out = brk_ff;
    assign motor_power_en = pwr_ff;

    // Pin pairs carry the brake only where allocated
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pair_ff <= '0;
        else
        begin
            for (int p = 0; p < hbs_pkg::N_PAIRS; p++)
                pair_ff[p] <= nxt_brk && (sel_ff[p*hbs_pkg::SEL_W +: hbs_pkg::SEL_W] == hbs_pkg::SEL_BRAKE);
        end
    end

    assign out_pair = pair_ff;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_on_pos;
        state_ff == hbs_pkg::ST_OFF && son_rise && !alarm && son_wait_ff > 0;
    endsequence
    sequence s_on_neg;
        state_ff == hbs_pkg::ST_OFF && son_rise && !alarm && son_wait_ff < 0;
    endsequence
    sequence s_stop_still;
        state_ff == hbs_pkg::ST_RUN && !servo_on_cmd && !alarm && !turning && soff_ms != '0;
    endsequence

    a_off_brake_hold: assert property (state_ff == hbs_pkg::ST_OFF |-> !brake_release_out && !motor_power_en)
        else $error("brake released or power on while off");
    a_pin_alloc_code: assert property ((out_pair[0] |-> sel_ff[0 +: hbs_pkg::SEL_W] == hbs_pkg::SEL_BRAKE) and
                                       (out_pair[1] |-> sel_ff[hbs_pkg::SEL_W +: hbs_pkg::SEL_W] == hbs_pkg::SEL_BRAKE))
        else $error("pin pair driven without brake code");
    a_stop_brake_first: assert property (s_stop_still |=> !brake_release_out && motor_power_en)
        else $error("stopped servo-off did not apply brake before power cut");
    a_pos_release_first: assert property (s_on_pos |=> brake_release_out && !motor_power_en)
        else $error("positive wait did not release brake first");
    a_neg_power_first: assert property (s_on_neg |=> motor_power_en && !brake_release_out)
        else $error("negative wait did not power motor first");
    a_alarm_power_cut: assert property (alarm && state_ff != hbs_pkg::ST_OFF |=> !motor_power_en)
        else $error("alarm did not cut power");
    a_rundown_speed: assert property (state_ff == hbs_pkg::ST_RUNDOWN && !turning |=> !brake_release_out)
        else $error("brake not applied below speed threshold");
    a_rundown_timeout: assert property (state_ff == hbs_pkg::ST_RUNDOWN && cnt_ms > bwait_ms
                                        |=> !brake_release_out)
        else $error("brake not applied after wait time");
    a_reset_defaults: assert property (!wr_seen_ff |-> thr_ff == hbs_pkg::THR_RST && bwait_ff == hbs_pkg::BWAIT_RST &&
                                       son_wait_ff == hbs_pkg::SON_RST && soff_wait_ff == hbs_pkg::SOFF_RST)
        else $error("setting lost its reset value");
    a_timer_cleared: assert property (state_ff != $past(state_ff) |-> cnt_ms == '0)
        else $error("delay counter not cleared on state change");
endmodule // hbs_top

`default_nettype wire

// ==== test/hbs_host_model.sv ====
// Purpose: Host controller model giving servo commands, alarm and speed
// Assumes: Bench requests change just after a rising clock edge
// Notes: Speed references are held back until the brake has had time to open
`timescale 1ns/1ps
`default_nettype none

module hbs_host_model #(
    parameter int unsigned CPM = 10,
    parameter int unsigned REL_MS = 5
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic on_req,
    input wire logic alm_req,
    input wire logic [hbs_pkg::SPD_W-1:0] spd_req,
    output logic servo_on_cmd,
    output logic alarm,
    output logic [hbs_pkg::SPD_W-1:0] motor_speed,
    output logic ref_ok
);
    logic [15:0] on_cnt_ff;

    // Commands registered so they only move after an edge
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            servo_on_cmd <= 1'b0;
            alarm <= 1'b0;
        end
        else
        begin
            servo_on_cmd <= on_req;
            alarm <= alm_req;
        end
    end

    // Time since servo-on; release time is a guess, real brakes vary
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            on_cnt_ff <= 16'h0000;
        else if (!servo_on_cmd)
            on_cnt_ff <= 16'h0000;
        else if (!ref_ok)
            on_cnt_ff <= on_cnt_ff + 16'h0001;
    end

    assign ref_ok = on_cnt_ff >= 16'((50 + REL_MS) * CPM);

    // No new reference while the brake may still be closed
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            motor_speed <= '0;
        else if (ref_ok || !on_req)
            motor_speed <= spd_req;
    end
endmodule // hbs_host_model

`default_nettype wire

// ==== test/hbs_top_tb.sv ====
// Purpose: Self-checking bench for the holding brake sequencer
// Assumes: Tick shortened to 10 clocks per millisecond
// Notes: Delays checked as windows of one tick plus sampling slack
`timescale 1ns/1ps
`default_nettype none

module hbs_top_tb;
    localparam logic [1:0] OK = hbs_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = hbs_pkg::RESP_SLVERR;
    logic sys_clk, rst, on_req, alm_req, servo_on_cmd, alarm, ref_ok;
    logic [15:0] spd_req, motor_speed;
    logic brake_release_out, motor_power_en;
    logic [1:0] out_pair, s_axi_bresp, s_axi_rresp;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int errors, num_checks, n, cyc;

    hbs_top #(.CYCLES_PER_MS(10)) dut (.sys_clk, .rst, .servo_on_cmd, .alarm, .motor_speed,
        .brake_release_out, .motor_power_en, .out_pair, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    hbs_host_model #(.CPM(10), .REL_MS(5)) host (.sys_clk, .rst, .on_req, .alm_req, .spd_req,
        .servo_on_cmd, .alarm, .motor_speed, .ref_ok);

    // Clock, 5 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        begin
            num_checks++;
            if (got !== exp)
            begin
                errors++;
                $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task automatic rng(input int v, input int lo, input int hi);
        check(32'(v >= lo && v <= hi), 32'h0000_0001);
    endtask

    // Edges until brake (0) or power (1) reaches a level, bounded
    task automatic wait_lvl(input int sel, input logic lvl, input int lim, output int k);
        begin
            k = 0;
            while (((sel == 0) ? brake_release_out : motor_power_en) !== lvl && k < lim)
            begin
                @(posedge sys_clk);
                k++;
            end
        end
    endtask

    task automatic wait_ref();
        begin
            for (n = 0; n < 700 && ref_ok !== 1'b1; n++)
                @(posedge sys_clk);
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do
            begin
                @(posedge sys_clk);
                if (s_axi_awvalid && s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready)
                    s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            check(s_axi_bresp, er);
            s_axi_bready <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do
            begin
                @(posedge sys_clk);
                if (s_axi_arvalid && s_axi_arready)
                    s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            check(s_axi_rdata, ed);
            check(s_axi_rresp, er);
            s_axi_rready <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task automatic summarize();
        begin
            $display("checks %0d mismatches %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            errors++;
            summarize();
        end
    end

    // Main sequence
    initial
    begin
        {rst, on_req, alm_req, spd_req} = {1'b1, 18'h0_0000};
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        check(brake_release_out, 1'b0);
        check(motor_power_en, 1'b0);
        check(out_pair, 2'b00);
        rd(hbs_pkg::OFS_SON, 32'h0000_0000, OK);
        rd(hbs_pkg::OFS_SOFF, 32'h0000_0000, OK);
        rd(hbs_pkg::OFS_THR, 32'h0000_0064, OK);
        rd(hbs_pkg::OFS_BWAIT, 32'h0000_0032, OK);
        rd(hbs_pkg::OFS_SEL, 32'h0000_00FF, OK);
        rd(8'h18, 32'h0000_0000, ERR);
        wr(hbs_pkg::OFS_STAT, 32'h0000_0000, ERR);
        wr(hbs_pkg::OFS_SEL, 32'h0000_004F, OK);
        $display("test reset and registers done");
        // Positive on-wait of 3 ms
        wr(hbs_pkg::OFS_SON, 32'h0000_0003, OK);
        on_req <= 1'b1;
        wait_lvl(0, 1'b1, 20, n);
        check(motor_power_en, 1'b0);
        wait_lvl(1, 1'b1, 60, n);
        rng(n, 29, 42);
        check(out_pair, 2'b10);
        rd(hbs_pkg::OFS_STAT, 32'h0000_0033, OK);
        $display("test positive on-wait done");
        // Stopped servo-off with 20 ms off-wait
        wr(hbs_pkg::OFS_SOFF, 32'h0000_0002, OK);
        on_req <= 1'b0;
        wait_lvl(0, 1'b0, 20, n);
        check(motor_power_en, 1'b1);
        wait_lvl(1, 1'b0, 300, n);
        rng(n, 199, 212);
        check(out_pair, 2'b00);
        $display("test stopped servo-off done");
        // Negative on-wait of 2 ms
        wr(hbs_pkg::OFS_SON, 32'h0000_0FFE, OK);
        on_req <= 1'b1;
        wait_lvl(1, 1'b1, 20, n);
        check(brake_release_out, 1'b0);
        wait_lvl(0, 1'b1, 60, n);
        rng(n, 19, 32);
        $display("test negative on-wait done");
        // Running stop ended by speed, threshold changed live
        wait_ref();
        check(ref_ok, 1'b1);
        spd_req <= 16'h01F4;
        repeat (3) @(posedge sys_clk);
        wr(hbs_pkg::OFS_THR, 32'h0000_0028, OK);
        on_req <= 1'b0;
        wait_lvl(1, 1'b0, 20, n);
        check(brake_release_out, 1'b1);
        spd_req <= 16'h0032;
        repeat (20) @(posedge sys_clk);
        check(brake_release_out, 1'b1);
        spd_req <= 16'h001E;
        wait_lvl(0, 1'b0, 8, n);
        rng(n, 0, 4);
        $display("test running stop by speed done");
        // Running stop ended by the 100 ms brake wait
        on_req <= 1'b1;
        wait_lvl(0, 1'b1, 60, n);
        check(brake_release_out, 1'b1);
        wait_ref();
        check(ref_ok, 1'b1);
        spd_req <= 16'h01F4;
        repeat (3) @(posedge sys_clk);
        wr(hbs_pkg::OFS_BWAIT, 32'h0000_000A, OK);
        on_req <= 1'b0;
        wait_lvl(1, 1'b0, 20, n);
        check(brake_release_out, 1'b1);
        wait_lvl(0, 1'b0, 1100, n);
        rng(n, 999, 1012);
        $display("test running stop by wait done");
        // Alarm while running stopped ignores a 500 ms off-wait
        spd_req <= 16'h0000;
        wr(hbs_pkg::OFS_SOFF, 32'h0000_0032, OK);
        on_req <= 1'b1;
        wait_lvl(0, 1'b1, 60, n);
        check(brake_release_out, 1'b1);
        alm_req <= 1'b1;
        wait_lvl(1, 1'b0, 8, n);
        rng(n, 0, 4);
        check(brake_release_out, 1'b0);
        alm_req <= 1'b0;
        on_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        $display("test alarm done");
        summarize();
    end
endmodule // hbs_top_tb

`default_nettype wire
